// File: rpsl_pkg.sv
// Package for the remote port set-up loader: register map, field layout,
// switch decoding and baud table. Assumes a 32-bit Avalon-MM register bus.
package rpsl_pkg;

  // Register byte offsets
  localparam logic [4:0] RPSL_OFS_STATUS = 5'h00;
  localparam logic [4:0] RPSL_OFS_STAGE = 5'h04;
  localparam logic [4:0] RPSL_OFS_UNLOCK = 5'h08;
  localparam logic [4:0] RPSL_OFS_LINK = 5'h0C;
  localparam logic [4:0] RPSL_OFS_ADDR = 5'h10;
  localparam logic [4:0] RPSL_OFS_EVENT = 5'h14;

  // Encodings of the two-switch fields
  localparam logic [1:0] RPSL_PAIR_ZERO = 2'h0;
  localparam logic [1:0] RPSL_PAIR_FIRST = 2'h1;
  localparam logic [1:0] RPSL_PAIR_SECOND = 2'h2;

  // Event bit positions
  localparam int RPSL_EV_CFG_ERR = 0;
  localparam int RPSL_EV_LINK_FAIL = 1;
  localparam int RPSL_EV_ADDR_ERR = 2;
  localparam int RPSL_EV_LOCKED = 3;

  localparam logic [7:0] RPSL_CR = 8'h0D;
  localparam logic [7:0] RPSL_LF = 8'h0A;
  localparam logic [7:0] RPSL_CRC_POLY = 8'h07;
  localparam logic [3:0] RPSL_BAUD_LAST = 4'hB;
  localparam logic [12:0] RPSL_LINK_RST = 13'h0000;

  // Link parameters, bit 12 downward as they sit in the registers
  typedef struct packed {
    logic term_crlf;
    logic [3:0] baud_code;
    logic flow_ctr;
    logic free_tune;
    logic [1:0] parity;
    logic crc;
    logic link_ctrl;
    logic [1:0] addr_len;
  } rpsl_link_s;

  // Addressing set-up held in one register
  typedef struct packed {
    logic sys_ctrl;
    logic fixed_mode;
    logic [6:0] fixed_addr;
    logic [6:0] rx2_addr;
    logic [6:0] rx1_addr;
  } rpsl_addr_s;

  // Unlisted pair combinations fall back to the all-off meaning
  function automatic logic [1:0] rpsl_pair(input logic [1:0] p);
    return (p == RPSL_PAIR_FIRST || p == RPSL_PAIR_SECOND) ? p : RPSL_PAIR_ZERO;
  endfunction

  // Baud rate for each code; codes past the table read as the all-off rate
  function automatic logic [13:0] rpsl_baud(input logic [3:0] c);
    case (c)
      4'h1: return 14'd75;
      4'h2: return 14'd110;
      4'h3: return 14'd150;
      4'h4: return 14'd300;
      4'h5: return 14'd600;
      4'h6: return 14'd1200;
      4'h7: return 14'd1800;
      4'h8: return 14'd2000;
      4'h9: return 14'd2400;
      4'hA: return 14'd4800;
      4'hB: return 14'd9600;
      default: return 14'd50;
    endcase
  endfunction

endpackage

// File: rpsl_loader.sv
// Remote port set-up loader: switch capture, remote configure protocol,
// menu access behind a security code, addressing and packet trailer.
// Assumes switch and pin inputs synchronous to clk_sys, Avalon-MM master.
//
// Behaviour
// - Source switch off takes local switches; on means ports configured remotely.
// - Switch parameters latched once after power-up; later switch changes ignored.
// - Four baud switches decode as a code, 50 up to 9600.
// - Address length and parity pairs decode to zero/one/two and none/odd/even.
// - Single switches enable link control, CRC, free tune; flow picks RTS/CTR.
// - RTS for modem-type equipment, clear-to-receive for terminal-type equipment.
// - Menu changes to link parameters refused until security code entered.
// - New parameters accepted only while configure low; applied on release.
// - Failed remote programming reported as configuration error or link failure.
// - Duplicate address for second receiver of dual unit rejected; code checks menu writes only, not the switch capture.
// - With CRC selected, a check byte is appended to each packet.
// - Packets end in CR alone or CR then LF, as configured.
// - A system-controller unit refuses slave control.
// - Fixed addressing controls one slave; variable takes address per selection.
// - Dual unit bus address: first receiver even, second answers plus one.
// - Bus port CRC and terminator each taken from one switch.
`timescale 1ns/1ps
module rpsl_loader
  import rpsl_pkg::*;
#(
  parameter logic [15:0] SEC_CODE = 16'h0000
)(
  // Clock and power-up reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Front-panel switches and straps
  input wire logic [7:0] sw_a,
  input wire logic [7:0] sw_b,
  input wire logic [6:0] addr_switch,
  input wire logic dual_unit,
  input wire logic bus_port,
  // Link side pins and events
  input wire logic configure_n,
  input wire logic link_fail,
  input wire logic [6:0] sel_addr,
  // Avalon-MM slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Packet data in
  input wire logic pkt_valid,
  input wire logic [7:0] pkt_data,
  input wire logic pkt_last,
  output logic pkt_ready,
  // Framed data out
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  // Applied set-up
  output rpsl_link_s link_cfg,
  output logic [13:0] baud_rate,
  output logic clear_to_receive,
  output logic remote_source,
  output logic [6:0] rx1_addr,
  output logic [6:0] rx2_addr,
  output logic [6:0] target_addr,
  output logic slave_accept
);

  typedef enum {RPSL_ST_DATA, RPSL_ST_CRC, RPSL_ST_CR, RPSL_ST_LF} rpsl_tail_e;

  rpsl_link_s active_r, stage_r, sw_link, wr_link;
  rpsl_addr_s addr_r, wr_addr;
  rpsl_tail_e tail_r, tail_nxt;
  logic cap_done_r, src_r, unlock_r, cfg_low_r, ack_r;
  logic [3:0] event_r, ev_set, ev_clr;
  logic [7:0] crc_r, crc_nxt, out_data_r;
  logic out_valid_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_go, rd_go, wr_stage, wr_unlock, wr_link_en, wr_addr_en, wr_event;
  logic release_ev, stage_ok, link_ok, addr_dup, addr_odd, addr_ok;
  logic slot_free, take_in, take_tail;
  logic [6:0] even_sw;

  // Switch decode: pairs sanitised, out-of-table baud codes fall to all-off
  assign sw_link.addr_len = rpsl_pair(sw_a[1:0]);
  assign sw_link.link_ctrl = sw_a[2];
  assign sw_link.crc = sw_a[3];
  assign sw_link.parity = rpsl_pair(sw_a[5:4]);
  assign sw_link.free_tune = sw_a[6];
  assign sw_link.flow_ctr = sw_a[7];
  assign sw_link.baud_code = (sw_b[3:0] > RPSL_BAUD_LAST) ? 4'h0 : sw_b[3:0];
  assign sw_link.term_crlf = sw_b[4];

  // Software writes go through the same sanitising as the switches
  assign wr_link.addr_len = rpsl_pair(avs_writedata[1:0]);
  assign wr_link.link_ctrl = avs_writedata[2];
  assign wr_link.crc = avs_writedata[3];
  assign wr_link.parity = rpsl_pair(avs_writedata[5:4]);
  assign wr_link.free_tune = avs_writedata[6];
  assign wr_link.flow_ctr = avs_writedata[7];
  assign wr_link.baud_code = (avs_writedata[11:8] > RPSL_BAUD_LAST) ? 4'h0
                             : avs_writedata[11:8];
  assign wr_link.term_crlf = avs_writedata[12];
  assign wr_addr = rpsl_addr_s'(avs_writedata[22:0]);

  // Bus handshake: one wait state, the write lands on the edge with waitrequest low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;
  assign rd_go = avs_read & ~ack_r;
  assign wr_stage = wr_go & (avs_address == RPSL_OFS_STAGE);
  assign wr_unlock = wr_go & (avs_address == RPSL_OFS_UNLOCK);
  assign wr_link_en = wr_go & (avs_address == RPSL_OFS_LINK);
  assign wr_addr_en = wr_go & (avs_address == RPSL_OFS_ADDR);
  assign wr_event = wr_go & (avs_address == RPSL_OFS_EVENT);

  // Acceptance conditions
  assign stage_ok = src_r & cfg_low_r & cap_done_r;
  assign link_ok = unlock_r & ~src_r;
  assign release_ev = cfg_low_r & configure_n & src_r & cap_done_r;
  assign addr_dup = dual_unit & ~bus_port & (wr_addr.rx2_addr == wr_addr.rx1_addr);
  assign addr_odd = dual_unit & bus_port & wr_addr.rx1_addr[0];
  assign addr_ok = unlock_r & ~addr_dup & ~addr_odd;
  assign even_sw = {addr_switch[6:1], 1'b0};

  // Events: a refused remote write is a configuration error
  assign ev_set[RPSL_EV_CFG_ERR] = wr_stage & ~stage_ok;
  assign ev_set[RPSL_EV_LINK_FAIL] = link_fail;
  assign ev_set[RPSL_EV_ADDR_ERR] = wr_addr_en & unlock_r & ~addr_ok;
  assign ev_set[RPSL_EV_LOCKED] = (wr_link_en & ~link_ok) | (wr_addr_en & ~unlock_r);
  assign ev_clr = wr_event ? avs_writedata[3:0] : 4'h0;

  // Read mux
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    unique case (avs_address)
      RPSL_OFS_STATUS: rdata_nxt = {27'h0, unlock_r, cfg_low_r, src_r, cap_done_r, 1'b0};
      RPSL_OFS_STAGE: rdata_nxt = {19'h0, stage_r};
      RPSL_OFS_LINK: rdata_nxt = {19'h0, active_r};
      RPSL_OFS_ADDR: rdata_nxt = {9'h0, addr_r};
      RPSL_OFS_EVENT: rdata_nxt = {28'h0, event_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Bus answer registers
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (rd_go)
        rdata_r <= rdata_nxt;
    end
  end
  assign avs_readdata = rdata_r;

  // Capture once after reset release; switches are then never looked at again
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cap_done_r <= 1'b0;
      src_r <= 1'b0;
      cfg_low_r <= 1'b0;
    end
    else
    begin
      cap_done_r <= 1'b1;
      if (!cap_done_r)
        src_r <= sw_b[7];
      cfg_low_r <= ~configure_n;
    end
  end

  // Applied link parameters
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      active_r <= rpsl_link_s'(RPSL_LINK_RST);
    else if (!cap_done_r && !sw_b[7])
      active_r <= sw_link;
    else if (release_ev)
      active_r <= stage_r;
    else if (wr_link_en && link_ok)
      active_r <= wr_link;
  end

  // Staged remote parameters, written only while configure is held low
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      stage_r <= rpsl_link_s'(RPSL_LINK_RST);
    else if (wr_stage && stage_ok)
      stage_r <= wr_link;
  end

  // Security lock: any wrong code locks again
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      unlock_r <= 1'b0;
    else if (wr_unlock)
      unlock_r <= (avs_writedata[15:0] == SEC_CODE);
  end

  // Addressing: switch address forced even on a bus-port dual unit
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      addr_r <= rpsl_addr_s'(23'h000000);
    else if (!cap_done_r)
    begin
      addr_r.rx1_addr <= (dual_unit && bus_port) ? even_sw : addr_switch;
      addr_r.rx2_addr <= 7'(even_sw + 7'h01);
    end
    else if (wr_addr_en && addr_ok)
    begin
      addr_r <= wr_addr;
      if (bus_port)
        addr_r.rx2_addr <= 7'(wr_addr.rx1_addr + 7'h01);
    end
  end

  // Sticky events, set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      event_r <= 4'h0;
    else
      event_r <= (event_r & ~ev_clr) | ev_set;
  end

  // Outputs of the applied set-up
  assign link_cfg = active_r;
  assign baud_rate = rpsl_baud(active_r.baud_code);
  assign clear_to_receive = active_r.flow_ctr;
  assign remote_source = src_r;
  assign rx1_addr = addr_r.rx1_addr;
  assign rx2_addr = dual_unit ? addr_r.rx2_addr : 7'h00;
  assign target_addr = addr_r.fixed_mode ? addr_r.fixed_addr : sel_addr;
  assign slave_accept = ~addr_r.sys_ctrl;

  // Packet trailer: data bytes, then optional check byte, CR, optional LF
  assign slot_free = ~out_valid_r | out_ready;
  assign pkt_ready = slot_free & (tail_r == RPSL_ST_DATA);
  assign take_in = pkt_valid & pkt_ready;
  assign take_tail = slot_free & (tail_r != RPSL_ST_DATA);

  // CRC-8 over the data bytes of one packet
  always_comb
  begin
    crc_nxt = crc_r ^ pkt_data;
    for (int i = 0; i < 8; i++)
      crc_nxt = crc_nxt[7] ? {crc_nxt[6:0], 1'b0} ^ RPSL_CRC_POLY : {crc_nxt[6:0], 1'b0};
  end

  // Next trailer state
  always_comb
  begin
    tail_nxt = tail_r;
    unique case (tail_r)
      RPSL_ST_DATA:
        if (take_in && pkt_last)
          tail_nxt = active_r.crc ? RPSL_ST_CRC : RPSL_ST_CR;
      RPSL_ST_CRC:
        if (take_tail)
          tail_nxt = RPSL_ST_CR;
      RPSL_ST_CR:
        if (take_tail)
          tail_nxt = active_r.term_crlf ? RPSL_ST_LF : RPSL_ST_DATA;
      RPSL_ST_LF:
        if (take_tail)
          tail_nxt = RPSL_ST_DATA;
    endcase
  end

  // Trailer registers; the output slot is a single stage, so data leaves in order
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tail_r <= RPSL_ST_DATA;
      crc_r <= 8'h00;
      out_valid_r <= 1'b0;
      out_data_r <= 8'h00;
    end
    else
    begin
      tail_r <= tail_nxt;
      if (take_in)
      begin
        out_data_r <= pkt_data;
        crc_r <= crc_nxt;
      end
      else if (take_tail)
      begin
        out_data_r <= (tail_r == RPSL_ST_CRC) ? crc_r
                      : (tail_r == RPSL_ST_CR) ? RPSL_CR : RPSL_LF;
        if (tail_r == RPSL_ST_CRC)
          crc_r <= 8'h00;
      end
      if (slot_free)
        out_valid_r <= take_in | take_tail;
    end
  end
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  // Checks
  sequence cfg_release_s;
    cfg_low_r && configure_n && src_r && cap_done_r;
  endsequence

  sequence tail_cr_s;
    take_tail && tail_r == RPSL_ST_CR;
  endsequence

  baud_table_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (active_r.baud_code == 4'h9 |-> baud_rate == 14'd2400) and
    (active_r.baud_code == 4'hB |-> baud_rate == 14'd9600))
    else $error("baud code decoded to wrong rate");

  pair_fallback_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (sw_a[1:0] == 2'h3 |-> sw_link.addr_len == RPSL_PAIR_ZERO) and
    (sw_a[5:4] == 2'h3 |-> sw_link.parity == RPSL_PAIR_ZERO))
    else $error("invalid switch pair not folded to zero");

  switch_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cap_done_r && !release_ev && !(wr_link_en && link_ok) |=> $stable(active_r))
    else $error("applied parameters moved without cause");

  source_latch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cap_done_r |=> $stable(src_r))
    else $error("source selection changed after capture");

  locked_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_link_en && !unlock_r |=> event_r[RPSL_EV_LOCKED])
    else $error("locked menu write not refused");

  stage_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_stage && !cfg_low_r |=> $stable(stage_r) && event_r[RPSL_EV_CFG_ERR])
    else $error("stage written with configure released");

  release_apply_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_release_s |=> active_r == $past(stage_r))
    else $error("staged parameters not applied on release");

  crc_before_cr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    take_tail && tail_r == RPSL_ST_CRC |=> tail_r == RPSL_ST_CR && out_data_r == $past(crc_r))
    else $error("check byte not followed by CR");

  crlf_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    tail_cr_s |=> out_data_r == RPSL_CR &&
    (tail_r == (active_r.term_crlf ? RPSL_ST_LF : RPSL_ST_DATA)))
    else $error("terminator sequence wrong");

  dual_plus_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_addr_en && addr_ok && bus_port |=> addr_r.rx2_addr == 7'($past(wr_addr.rx1_addr) + 7'h01))
    else $error("second receiver not at first plus one");

  no_dup_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_addr_en && unlock_r && addr_dup |=> $stable(addr_r) && event_r[RPSL_EV_ADDR_ERR])
    else $error("duplicate address accepted");

  sysctrl_slave_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    addr_r.sys_ctrl |-> !slave_accept)
    else $error("system controller accepts slave control");

  wait_one_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");

endmodule // rpsl_loader

// File: rpsl_remote_ctrl.sv
// Partner model: the remote controller on the serial link. It works the
// configure pin on request from the bench and drains framed output slowly.
`timescale 1ns/1ps
module rpsl_remote_ctrl (
  // Clock
  input wire logic clk_sys,
  // Bench request to hold the configure pin
  input wire logic hold_cfg,
  // Framed data from the loader
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  // Pins driven by the controller
  output logic configure_n,
  output logic out_ready
);
  logic [7:0] got_q[$];

  // Pin released reads high; held at 0 V only while the bench asks for transfer
  initial configure_n = 1'b1;
  initial out_ready = 1'b0;
  always @(posedge clk_sys)
  begin
    configure_n <= ~hold_cfg;
    out_ready <= ~out_ready; // Stalls every other cycle, the slow case
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      got_q.push_back(out_data);
    end
  end
endmodule // rpsl_remote_ctrl

// File: rpsl_loader_test.sv
// Self-checking bench for the loader: switch capture, menu, addressing,
// remote configure and packet trailer. Assumes the partner model above.
`timescale 1ns/1ps
module rpsl_loader_test;
  import rpsl_pkg::*;
  logic clk_sys, sys_rst, dual_unit, bus_port, link_fail, hold_cfg, configure_n;
  logic [7:0] sw_a, sw_b, pkt_data, out_data;
  logic [6:0] addr_switch, sel_addr, rx1_addr, rx2_addr, target_addr;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, pkt_valid, pkt_last, pkt_ready;
  logic out_valid, out_ready, clear_to_receive, remote_source, slave_accept;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [13:0] baud_rate;
  rpsl_link_s link_cfg;
  int fail_count, n_compared, cyc;
  logic [13:0] baud_tab [16] = '{14'd50, 14'd75, 14'd110, 14'd150, 14'd300, 14'd600,
    14'd1200, 14'd1800, 14'd2000, 14'd2400, 14'd4800, 14'd9600, 14'd50, 14'd50, 14'd50, 14'd50};

  rpsl_loader rpsl_loader_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .sw_a(sw_a), .sw_b(sw_b),
    .addr_switch(addr_switch), .dual_unit(dual_unit), .bus_port(bus_port),
    .configure_n(configure_n), .link_fail(link_fail), .sel_addr(sel_addr),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .link_cfg(link_cfg), .baud_rate(baud_rate),
    .clear_to_receive(clear_to_receive), .remote_source(remote_source), .rx1_addr(rx1_addr),
    .rx2_addr(rx2_addr), .target_addr(target_addr), .slave_accept(slave_accept));
  rpsl_remote_ctrl rpsl_remote_ctrl_i (.clk_sys(clk_sys), .hold_cfg(hold_cfg),
    .out_valid(out_valid), .out_data(out_data), .configure_n(configure_n),
    .out_ready(out_ready));

  // Free-running 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Power-up: hold reset 12 cycles, then let the capture edge pass
  task automatic do_reset;
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low at a rising edge.
  // Only the hang guard ends a wait; one idle edge lets a landed write reach the outputs.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do
      @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  // One-byte packet held until ready is sampled high, then time for the trailer to drain
  task automatic send1(input logic [7:0] b);
    @(posedge clk_sys);
    {pkt_valid, pkt_last, pkt_data} <= {2'b11, b};
    do
      @(posedge clk_sys);
    while (pkt_ready !== 1'b1);
    {pkt_valid, pkt_last} <= 2'b00;
    repeat (20) @(posedge clk_sys);
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, q & m, exp);
  endtask

  // Reference CRC-8, polynomial 0x07, zero start, over one byte
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = b;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction

  function automatic logic [1:0] pr(input logic [1:0] p);
    return (p == 2'h3) ? 2'h0 : p;
  endfunction

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {dual_unit, bus_port, link_fail, hold_cfg, avs_read, avs_write} = '0;
    {pkt_valid, pkt_last, pkt_data, avs_address, avs_writedata} = '0;
    {sw_a, sw_b, addr_switch, sel_addr} = '0;
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    // Every switch code captured at power-up, unlisted pairs included
    for (int c = 0; c < 16; c++)
    begin
      sw_a <= {c[3], c[2], c[1], c[0], c[0], c[1], c[1], c[0]};
      sw_b <= {4'h0, c[3:0]};
      do_reset();
      chk("link_cfg", link_cfg, {1'b0, (c[3:0] > RPSL_BAUD_LAST) ? 4'h0 : c[3:0], c[3], c[2],
        pr(c[1:0]), c[0], c[1], pr(c[1:0])});
      chk("baud_rate", baud_rate, baud_tab[c]);
      chk("ctr", clear_to_receive, c[3]);
      chk("source", remote_source, 1'b0);
    end
    sw_a <= 8'hFF;
    sw_b <= 8'h9F;
    repeat (4) @(posedge clk_sys);
    chk("held", link_cfg, 13'h00CC);
    rdchk("status", RPSL_OFS_STATUS, 32'h6, 32'h2);
    $display("switch capture test done");
    // Menu writes refused while locked, accepted after the code
    sw_a <= 8'h00;
    sw_b <= 8'h00;
    do_reset();
    bus(1'b1, RPSL_OFS_LINK, 32'h0901);
    rdchk("locked", RPSL_OFS_LINK, 32'h1FFF, 32'h0);
    rdchk("lock_ev", RPSL_OFS_EVENT, 32'h8, 32'h8);
    bus(1'b1, RPSL_OFS_UNLOCK, 32'h0);
    bus(1'b1, RPSL_OFS_LINK, 32'h0901);
    rdchk("link", RPSL_OFS_LINK, 32'h1FFF, 32'h0901);
    chk("baud", baud_rate, 14'd2400);
    rdchk("unmapped", 5'h18, 32'hFFFFFFFF, 32'h0);
    @(posedge clk_sys);
    link_fail <= 1'b1;
    @(posedge clk_sys);
    link_fail <= 1'b0;
    rdchk("link_ev", RPSL_OFS_EVENT, 32'h2, 32'h2);
    bus(1'b1, RPSL_OFS_EVENT, 32'hF);
    rdchk("ev_clr", RPSL_OFS_EVENT, 32'hF, 32'h0);
    $display("menu test done");
    // Dual serial unit: duplicate refused, then fixed and variable addressing
    dual_unit <= 1'b1;
    sel_addr <= 7'h33;
    bus(1'b1, RPSL_OFS_ADDR, 32'h0285);
    rdchk("dup", RPSL_OFS_ADDR, 32'h7FFFFF, 32'h80);
    rdchk("dup_ev", RPSL_OFS_EVENT, 32'h4, 32'h4);
    bus(1'b1, RPSL_OFS_ADDR, 32'h00684304);
    chk("rx1", rx1_addr, 7'h04);
    chk("rx2", rx2_addr, 7'h06);
    chk("fixed", target_addr, 7'h21);
    chk("sysctl", slave_accept, 1'b0);
    bus(1'b1, RPSL_OFS_ADDR, 32'h00084304);
    chk("var", target_addr, 7'h33);
    chk("slave", slave_accept, 1'b1);
    // Bus port dual: even first address, second one above
    bus_port <= 1'b1;
    addr_switch <= 7'h0B;
    do_reset();
    chk("even", rx1_addr, 7'h0A);
    chk("plus1", rx2_addr, 7'h0B);
    bus(1'b1, RPSL_OFS_UNLOCK, 32'h0);
    bus(1'b1, RPSL_OFS_ADDR, 32'h0407);
    rdchk("odd_ev", RPSL_OFS_EVENT, 32'h4, 32'h4);
    $display("address test done");
    // Remote source: staging only while the configure pin is low
    {dual_unit, bus_port} <= 2'b00;
    sw_b <= 8'h80;
    do_reset();
    chk("remote", remote_source, 1'b1);
    bus(1'b1, RPSL_OFS_STAGE, 32'h1A0A);
    hold_cfg <= 1'b1;
    repeat (4) @(posedge clk_sys);
    hold_cfg <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("no_stage", link_cfg, 13'h0);
    rdchk("cfg_ev", RPSL_OFS_EVENT, 32'h1, 32'h1);
    hold_cfg <= 1'b1;
    bus(1'b1, RPSL_OFS_STAGE, 32'h1A0A);
    repeat (3) @(posedge clk_sys);
    chk("not_yet", link_cfg, 13'h0);
    hold_cfg <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("applied", link_cfg, 13'h1A0A);
    // One-byte packet with check byte and CR LF trailer, far side stalling
    send1(8'h5A);
    chk("n_bytes", rpsl_remote_ctrl_i.got_q.size(), 32'd4);
    if (rpsl_remote_ctrl_i.got_q.size() == 4)
    begin
      chk("byte", rpsl_remote_ctrl_i.got_q[0], 8'h5A);
      chk("crc", rpsl_remote_ctrl_i.got_q[1], crc8(8'h5A));
      chk("cr", rpsl_remote_ctrl_i.got_q[2], RPSL_CR);
      chk("lf", rpsl_remote_ctrl_i.got_q[3], RPSL_LF);
    end
    // Check byte off and CR alone: only the data byte and CR follow
    hold_cfg <= 1'b1;
    bus(1'b1, RPSL_OFS_STAGE, 32'h0002);
    hold_cfg <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("applied2", link_cfg, 13'h0002);
    send1(8'h3C);
    chk("n_bytes2", rpsl_remote_ctrl_i.got_q.size(), 32'd6);
    if (rpsl_remote_ctrl_i.got_q.size() == 6)
    begin
      chk("byte2", rpsl_remote_ctrl_i.got_q[4], 8'h3C);
      chk("cr2", rpsl_remote_ctrl_i.got_q[5], RPSL_CR);
    end
    $display("remote and packet test done");
    end_sim();
  end
endmodule // rpsl_loader_test
